// ===== asv_defs.vh
`ifndef ASV_DEFS_VH
`define ASV_DEFS_VH

// ==========================================================
// Register byte offsets
`define ASV_OFF_CTRL    8'h00
`define ASV_OFF_COEF    8'h04
`define ASV_OFF_CFG     8'h08
`define ASV_OFF_CMD     8'h0C
`define ASV_OFF_STAT    8'h10
`define ASV_OFF_EVT     8'h14
`define ASV_OFF_CAPT    8'h18
`define ASV_OFF_SPD     8'h1C

// ==========================================================
// Control word bits
`define ASV_CTL_PAUSE   0
`define ASV_CTL_AUTO    1
`define ASV_CTL_RUN     2
`define ASV_CTL_COMM    3
`define ASV_CTL_STOP    4
`define ASV_CTL_BLKERR  5
`define ASV_CTRL_W      6
`define ASV_CTRL_RST    6'h00
`define ASV_EVACK_BIT   0

// Speed modulation coefficient
`define ASV_COEF_RST    16'h03E8
`define ASV_COEF_DIV    32'h000003E8

// Movement command word fields
`define ASV_CMD_CODE    7:0
`define ASV_CMD_EVEN    12
`define ASV_CMD_SPD     31:16

// Instruction codes
`define ASV_CODE_AWAIT  8'h05
`define ASV_CODE_CAPT   8'h07
`define ASV_CODE_STOP   8'h09
`define ASV_CODE_UNTS   8'h0A
`define ASV_CODE_UNTC   8'h0B

// Event cause bits
`define ASV_EV_CAPT     0
`define ASV_EV_HIT      1
`define ASV_EV_TOUT     2
`define ASV_EV_UNTIL    3

// Synchronised pin indexes
`define ASV_IN_STOK     0
`define ASV_IN_REST     1
`define ASV_IN_DONE     2
`define ASV_IN_PASS     3
`define ASV_IN_EVT      4
`define ASV_IN_N        5

// Timing and sizes
`define ASV_ST_CYCLES   16
`define ASV_Q_DEPTH     2

`endif

// ===== asv_axis_supervisor.v
// Added by the designer: the register offsets and the AHB-Lite slave port.
`include "asv_defs.vh"

module asv_axis_supervisor #(
  parameter SELFTEST_CYCLES = `ASV_ST_CYCLES
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  // Motion engine pins
  input  wire        SELFTEST_OK,
  input  wire        AT_REST,
  input  wire        MOVE_DONE,
  input  wire        TARGET_PASSED,
  input  wire        EVENT_IN,
  input  wire [31:0] POSITION,
  // Motion engine orders
  output wire        MOVE_START,
  output wire [7:0]  MOVE_CODE,
  output wire [31:0] MOVE_SPEED,
  output wire        DECEL_REQ,
  output wire        OUT_ENABLE,
  // Status to controller
  output wire        EVT_TASK,
  output wire        PAUSED,
  output wire        FEED_HOLD
);

  // ==========================================================
  // Modes
  localparam [2:0] M_TEST = 3'h0;
  localparam [2:0] M_CHK  = 3'h1;
  localparam [2:0] M_OFF  = 3'h2;
  localparam [2:0] M_RUN  = 3'h3;
  localparam [2:0] M_STOP = 3'h4;
  localparam [2:0] M_ERR  = 3'h5;
  localparam integer ST_LAST = SELFTEST_CYCLES - 1;

  // Product of base speed and coefficient, divided by 1000
  function [31:0] scale_spd;
    input [15:0] f;
    input [15:0] c;
    reg   [31:0] p;
    begin
      p = f * c;
      scale_spd = p / `ASV_COEF_DIV;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers with agreement filter
  wire [`ASV_IN_N-1:0] pins = {EVENT_IN, TARGET_PASSED, MOVE_DONE, AT_REST, SELFTEST_OK};
  wire [`ASV_IN_N-1:0] flt_r;
  reg  [`ASV_IN_N-1:0] prev_r;
  genvar g;
  generate
    for (g = 0; g < `ASV_IN_N; g = g + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg f_r;
      // Three stages; level taken once stages two and three agree
      always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          s1_r     <= 1'b0;
          s2_r     <= 1'b0;
          s3_r     <= 1'b0;
          f_r      <= 1'b0;
        end else begin
          s1_r <= pins[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            f_r <= s3_r;
        end
      end
      // Filtered level of this pin
      assign flt_r[g] = f_r;
    end
  endgenerate

  // Edge history
  always @(posedge CLK or posedge RESET) begin
    if (RESET)
      prev_r <= {`ASV_IN_N{1'b0}};
    else
      prev_r <= flt_r;
  end

  wire at_rest = flt_r[`ASV_IN_REST];
  wire done_p  = flt_r[`ASV_IN_DONE] & ~prev_r[`ASV_IN_DONE];
  wire evt_p   = flt_r[`ASV_IN_EVT] & ~prev_r[`ASV_IN_EVT];

  // ==========================================================
  // AHB-Lite slave: one wait state, registered answer
  reg        dp_r;
  reg        dp_wr_r;
  reg [7:0]  dp_adr_r;
  reg        hready_r;
  reg [31:0] hrdata_r;
  reg [31:0] rd_mux;
  wire       acc   = HSEL & HTRANS[1] & HREADY;
  wire       wr_en = dp_r & dp_wr_r;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dp_r     <= 1'b0;
      dp_wr_r  <= 1'b0;
      dp_adr_r <= 8'h00;
      hready_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else if (acc) begin
      dp_r     <= 1'b1;
      dp_wr_r  <= HWRITE;
      dp_adr_r <= HADDR[7:0];
      hready_r <= 1'b0;
    end else if (dp_r) begin
      dp_r     <= 1'b0;
      hready_r <= 1'b1;
      if (!dp_wr_r)
        hrdata_r <= rd_mux;
    end
  end

  assign HRDATA    = hrdata_r;
  assign HREADYOUT = hready_r;
  assign HRESP     = 1'b0;

  // ==========================================================
  // Software registers
  reg [`ASV_CTRL_W-1:0] ctrl_r;
  reg [15:0]            coef_r;
  reg [31:0]            cfg_r;
  wire cfg_wr = wr_en & (dp_adr_r == `ASV_OFF_CFG);
  wire ev_ack = wr_en & (dp_adr_r == `ASV_OFF_EVT) & HWDATA[`ASV_EVACK_BIT];

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_r <= `ASV_CTRL_RST;
      coef_r <= `ASV_COEF_RST;
      cfg_r  <= 32'h00000000;
    end else if (wr_en) begin
      if (dp_adr_r == `ASV_OFF_CTRL)
        ctrl_r <= HWDATA[`ASV_CTRL_W-1:0];
      if (dp_adr_r == `ASV_OFF_COEF)
        coef_r <= HWDATA[15:0];
      if (cfg_wr)
        cfg_r <= HWDATA;
    end
  end

  wire pause_req = ctrl_r[`ASV_CTL_PAUSE];
  wire auto_m    = ctrl_r[`ASV_CTL_AUTO];
  wire plc_run   = ctrl_r[`ASV_CTL_RUN] & ctrl_r[`ASV_CTL_COMM];
  wire abort     = ctrl_r[`ASV_CTL_STOP] | ctrl_r[`ASV_CTL_BLKERR];

  // ==========================================================
  // Operating mode machine
  reg [2:0]  mode_r;
  reg [15:0] st_cnt_r;
  reg        recfg_r;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mode_r   <= M_TEST;
      st_cnt_r <= 16'h0000;
      recfg_r  <= 1'b0;
    end else begin
      case (mode_r)
        M_TEST: begin
          st_cnt_r <= st_cnt_r + 16'h0001;
          if (st_cnt_r == ST_LAST[15:0])
            mode_r <= flt_r[`ASV_IN_STOK] ? M_CHK : M_ERR;
        end
        M_CHK: mode_r <= (cfg_r != 32'h00000000) ? M_OFF : M_ERR;
        M_OFF: begin
          if (cfg_wr)
            mode_r <= M_CHK;
          else if (plc_run)
            mode_r <= M_RUN;
        end
        M_RUN: begin
          if (cfg_wr) begin
            recfg_r <= 1'b1;
            mode_r  <= M_STOP;
          end else if (!plc_run)
            mode_r <= M_STOP;
        end
        M_STOP: begin
          if (cfg_wr)
            recfg_r <= 1'b1;
          if (at_rest) begin
            mode_r  <= (recfg_r | cfg_wr) ? M_CHK : M_OFF;
            recfg_r <= 1'b0;
          end
        end
        M_ERR: begin
          if (cfg_wr)
            mode_r <= M_CHK;
        end
        default: mode_r <= M_TEST;
      endcase
    end
  end

  wire run_m = (mode_r == M_RUN);
  wire cfg_ok = ((mode_r == M_OFF) | run_m | (mode_r == M_STOP)) & ~recfg_r;

  // ==========================================================
  // Movement sequencer with command buffer
  reg [31:0] q_r [0:`ASV_Q_DEPTH-1];
  reg [1:0]  q_cnt_r;
  reg [31:0] exec_r;
  reg        exec_v_r;
  reg        paused_r;
  reg        hold_r;
  reg        passed_r;
  integer    i;

  wire [7:0] ecode    = exec_r[`ASV_CMD_CODE];
  wire       stop_typ = (ecode == `ASV_CODE_STOP) | (ecode == `ASV_CODE_UNTS);
  wire       coef_nz  = (coef_r != 16'h0000);
  wire       q_room   = (q_cnt_r < `ASV_Q_DEPTH);
  wire       push     = wr_en & (dp_adr_r == `ASV_OFF_CMD) & run_m & q_room;
  wire       fin      = exec_v_r & ~hold_r & (done_p | (ecode == `ASV_CODE_CAPT) |
                        ((ecode == `ASV_CODE_AWAIT) & evt_p));
  wire       pause_tk = fin & auto_m & pause_req & stop_typ;
  wire       drop     = hold_r & coef_nz & passed_r;
  wire       resume   = hold_r & coef_nz & ~passed_r & run_m & ~abort;
  wire       pop      = run_m & ~abort & (q_cnt_r != 2'h0) & (~exec_v_r | fin | drop) &
                        ~pause_tk & ~paused_r & (~hold_r | drop);
  wire [1:0] wr_idx   = q_cnt_r - {1'b0, pop};

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      for (i = 0; i < `ASV_Q_DEPTH; i = i + 1)
        q_r[i] <= 32'h00000000;
      q_cnt_r  <= 2'h0;
      exec_r   <= 32'h00000000;
      exec_v_r <= 1'b0;
      paused_r <= 1'b0;
      hold_r   <= 1'b0;
      passed_r <= 1'b0;
    end else if (!run_m || abort) begin
      q_cnt_r  <= 2'h0;
      exec_v_r <= 1'b0;
      paused_r <= 1'b0;
      hold_r   <= 1'b0;
      passed_r <= 1'b0;
    end else begin
      if (pop) begin
        exec_r   <= q_r[0];
        exec_v_r <= 1'b1;
      end else if (fin || drop)
        exec_v_r <= 1'b0;
      // Shift on pop, append on push
      for (i = 0; i < `ASV_Q_DEPTH; i = i + 1) begin
        if (pop && i < `ASV_Q_DEPTH - 1)
          q_r[i] <= q_r[i+1];
        if (push && i == wr_idx)
          q_r[i] <= HWDATA;
      end
      q_cnt_r <= q_cnt_r + {1'b0, push} - {1'b0, pop};
      // Standby after a stop move; leaves once request drops
      if (pause_tk)
        paused_r <= 1'b1;
      else if (!pause_req || !auto_m)
        paused_r <= 1'b0;
      // Feed hold in automatic mode: set by a zero coefficient during a move, cleared when it is non-zero
      if (!coef_nz && exec_v_r && auto_m)
        hold_r <= 1'b1;
      else if (coef_nz)
        hold_r <= 1'b0;
      if (!hold_r)
        passed_r <= 1'b0;
      else if (at_rest && flt_r[`ASV_IN_PASS])
        passed_r <= 1'b1;
    end
  end

  // ==========================================================
  // Event trigger generation
  reg        cap_arm_r;
  reg        cap_en_r;
  reg        cap_done_r;
  reg [31:0] cap_stage_r;
  reg [3:0]  ev_flags_r;
  reg        ev_ovr_r;
  reg        ev_pend_r;
  reg [31:0] capt_pub_r;
  reg        evt_task_r;
  reg [3:0]  cause;

  wire e_en = exec_v_r & exec_r[`ASV_CMD_EVEN];

  // Cause of a trigger in this cycle
  always @* begin
    cause = 4'h0;
    cause[`ASV_EV_UNTIL] = e_en & evt_p &
                           ((ecode == `ASV_CODE_UNTS) | (ecode == `ASV_CODE_UNTC));
    cause[`ASV_EV_HIT]   = e_en & evt_p & (ecode == `ASV_CODE_AWAIT);
    cause[`ASV_EV_TOUT]  = e_en & done_p & ~evt_p & (ecode == `ASV_CODE_AWAIT);
    cause[`ASV_EV_CAPT]  = cap_done_r;
  end

  wire trig = |cause;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cap_arm_r   <= 1'b0;
      cap_en_r    <= 1'b0;
      cap_done_r  <= 1'b0;
      cap_stage_r <= 32'h00000000;
      ev_flags_r  <= 4'h0;
      ev_ovr_r    <= 1'b0;
      ev_pend_r   <= 1'b0;
      capt_pub_r  <= 32'h00000000;
      evt_task_r  <= 1'b0;
    end else begin
      // Capture armed by its instruction, stored on the event
      cap_done_r <= 1'b0;
      if (!run_m) begin
        cap_arm_r <= 1'b0;
      end else if (pop && q_r[0][`ASV_CMD_CODE] == `ASV_CODE_CAPT) begin
        cap_arm_r <= 1'b1;
        cap_en_r  <= q_r[0][`ASV_CMD_EVEN];
      end else if (cap_arm_r && evt_p) begin
        cap_arm_r   <= 1'b0;
        cap_stage_r <= POSITION;
        cap_done_r  <= cap_en_r;
      end
      // Publish only on a trigger; set wins over acknowledge
      evt_task_r <= trig;
      if (trig) begin
        ev_flags_r <= cause;
        ev_ovr_r   <= ev_pend_r | (cap_arm_r & evt_p & cap_done_r);
        ev_pend_r  <= 1'b1;
        if (cause[`ASV_EV_CAPT])
          capt_pub_r <= cap_stage_r;
      end else if (ev_ack) begin
        ev_pend_r <= 1'b0;
        ev_ovr_r  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Orders toward the motion engine
  reg        mv_start_r;
  reg [7:0]  mv_code_r;
  reg [31:0] mv_spd_r;
  reg        decel_r;
  reg        out_en_r;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mv_start_r <= 1'b0;
      mv_code_r  <= 8'h00;
      mv_spd_r   <= 32'h00000000;
      decel_r    <= 1'b0;
      out_en_r   <= 1'b0;
    end else begin
      mv_start_r <= pop | resume;
      if (pop) begin
        mv_code_r <= q_r[0][`ASV_CMD_CODE];
        mv_spd_r  <= scale_spd(q_r[0][`ASV_CMD_SPD], coef_r);
      end else if (resume) begin
        mv_spd_r  <= scale_spd(exec_r[`ASV_CMD_SPD], coef_r);
      end
      decel_r  <= (hold_r & ~coef_nz) | (mode_r == M_STOP) | (run_m & abort);
      out_en_r <= run_m | (mode_r == M_STOP);
    end
  end

  assign MOVE_START = mv_start_r;
  assign MOVE_CODE  = mv_code_r;
  assign MOVE_SPEED = mv_spd_r;
  assign DECEL_REQ  = decel_r;
  assign OUT_ENABLE = out_en_r;
  assign EVT_TASK   = evt_task_r;
  assign PAUSED     = paused_r;
  assign FEED_HOLD  = hold_r;

  // ==========================================================
  // Read multiplexer; unmapped reads as zero
  always @* begin
    case (dp_adr_r)
      `ASV_OFF_CTRL: rd_mux = {26'h0000000, ctrl_r};
      `ASV_OFF_COEF: rd_mux = {16'h0000, coef_r};
      `ASV_OFF_CFG:  rd_mux = cfg_r;
      `ASV_OFF_STAT: rd_mux = {20'h00000, q_cnt_r, mode_r, (mode_r == M_ERR), cfg_ok,
                               hold_r, paused_r, exec_v_r, (~exec_v_r & (q_cnt_r == 2'h0)), q_room};
      `ASV_OFF_EVT:  rd_mux = {26'h0000000, ev_pend_r, ev_ovr_r, ev_flags_r};
      `ASV_OFF_CAPT: rd_mux = capt_pub_r;
      `ASV_OFF_SPD:  rd_mux = mv_spd_r;
      default:       rd_mux = 32'h00000000;
    endcase
  end

endmodule

// ===== asv_axis_supervisor_monitor.sv
module asv_axis_supervisor_monitor #(
  parameter SELFTEST_CYCLES = 16
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Bus answer
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Motion side
  input wire logic        AT_REST,
  input wire logic        MOVE_START,
  input wire logic [31:0] MOVE_SPEED,
  input wire logic        DECEL_REQ,
  input wire logic        OUT_ENABLE,
  // Status side
  input wire logic        EVT_TASK,
  input wire logic        PAUSED,
  input wire logic        FEED_HOLD
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_start_gate; MOVE_START |-> !PAUSED && !FEED_HOLD; endproperty
  a_start_gate: assert property (p_start_gate) else $error("start while paused or held");
  property p_pause_rest; $rose(PAUSED) |-> AT_REST; endproperty
  a_pause_rest: assert property (p_pause_rest) else $error("pause entered while moving");
  property p_hold_decel; $rose(FEED_HOLD) |-> ##[0:1] DECEL_REQ; endproperty
  a_hold_decel: assert property (p_hold_decel) else $error("hold without deceleration");
  property p_speed_change; $changed(MOVE_SPEED) |-> MOVE_START; endproperty
  a_speed_change: assert property (p_speed_change) else $error("speed changed without start");
  property p_evt_pulse; EVT_TASK |=> !EVT_TASK; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event trigger longer than a cycle");
  property p_safe_out; !OUT_ENABLE |-> !MOVE_START && !DECEL_REQ; endproperty
  a_safe_out: assert property (p_safe_out) else $error("motion order with outputs safe");
  property p_start_pulse; MOVE_START |=> !MOVE_START; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than a cycle");
  property p_one_wait; !HREADYOUT |=> HREADYOUT; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state longer than one cycle");
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
endmodule

bind asv_axis_supervisor asv_axis_supervisor_monitor #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) asv_mon_i (
  .CLK(CLK), .RESET(RESET), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .AT_REST(AT_REST),
  .MOVE_START(MOVE_START), .MOVE_SPEED(MOVE_SPEED), .DECEL_REQ(DECEL_REQ), .OUT_ENABLE(OUT_ENABLE),
  .EVT_TASK(EVT_TASK), .PAUSED(PAUSED), .FEED_HOLD(FEED_HOLD));

// ===== asv_motion_model.sv
module asv_motion_model #(
  parameter DUR = 40
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // Orders from the block; event request from the testbench
  input  wire logic        MOVE_START,
  input  wire logic [7:0]  MOVE_CODE,
  input  wire logic        DECEL_REQ,
  input  wire logic        ev_req,
  // Pins toward the block
  output logic             SELFTEST_OK,
  output logic             AT_REST,
  output logic             MOVE_DONE,
  output logic             TARGET_PASSED,
  output logic             EVENT_IN,
  output logic [31:0]      POSITION
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  logic ev_d;
  // ==========================================================
  // Fixed pins: self-test passes, target never overshot; event pin follows the request
  assign SELFTEST_OK   = 1'b1;
  assign TARGET_PASSED = 1'b0;
  assign EVENT_IN      = ev_req;
  // Movement timing; a ramp request stops without finishing
  // Await ends at rest on the event, done only on time-out; capture does not move
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AT_REST   <= 1'b1;
      MOVE_DONE <= 1'b0;
      cnt       <= 0;
      POSITION  <= 32'h0;
      ev_d      <= 1'b0;
    end else begin
      ev_d <= ev_req;
      if (MOVE_START && MOVE_CODE != 8'h07) begin
        AT_REST   <= 1'b0;
        MOVE_DONE <= 1'b0;
        cnt       <= DUR;
      end else if (!AT_REST) begin
        POSITION <= POSITION + 32'h1;
        cnt      <= cnt - 1;
        if (DECEL_REQ) begin
          AT_REST <= 1'b1;
        end else if (MOVE_CODE == 8'h05 && ev_req && !ev_d) begin
          AT_REST <= 1'b1;
        end else if (cnt == 1) begin
          AT_REST   <= 1'b1;
          MOVE_DONE <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== asv_testbench.sv
`include "asv_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK, RESET, HWRITE, ev, AT_REST, MOVE_DONE, TARGET_PASSED, EVENT_IN, SELFTEST_OK;
  logic        HREADYOUT, HRESP, MOVE_START, DECEL_REQ, OUT_ENABLE, EVT_TASK, PAUSED, FEED_HOLD;
  logic [1:0]  HTRANS;
  logic [31:0] HADDR, HWDATA, HRDATA, MOVE_SPEED, POSITION, q, pos;
  logic [7:0]  MOVE_CODE;
  int          bad_count, samples_checked, cyc, evt_n;
  wire  [3:0]  mon = {EVT_TASK, FEED_HOLD, PAUSED, MOVE_START};
  // ==========================================================
  // Design, far side and clock
  asv_axis_supervisor #(.SELFTEST_CYCLES(8)) asv_axis_supervisor_i (.CLK(CLK), .RESET(RESET),
    .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .SELFTEST_OK(SELFTEST_OK), .AT_REST(AT_REST), .MOVE_DONE(MOVE_DONE), .TARGET_PASSED(TARGET_PASSED),
    .EVENT_IN(EVENT_IN), .POSITION(POSITION), .MOVE_START(MOVE_START), .MOVE_CODE(MOVE_CODE),
    .MOVE_SPEED(MOVE_SPEED), .DECEL_REQ(DECEL_REQ), .OUT_ENABLE(OUT_ENABLE), .EVT_TASK(EVT_TASK),
    .PAUSED(PAUSED), .FEED_HOLD(FEED_HOLD));
  asv_motion_model asv_motion_model_i (.CLK(CLK), .RESET(RESET), .MOVE_START(MOVE_START),
    .MOVE_CODE(MOVE_CODE), .DECEL_REQ(DECEL_REQ), .ev_req(ev), .SELFTEST_OK(SELFTEST_OK),
    .AT_REST(AT_REST), .MOVE_DONE(MOVE_DONE), .TARGET_PASSED(TARGET_PASSED), .EVENT_IN(EVENT_IN),
    .POSITION(POSITION));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Cycle ceiling and trigger count
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (EVT_TASK === 1'b1) evt_n <= evt_n + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count = bad_count + 1;
    end
  endtask
  // Single word transfer, held until ready is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic r;
    @(posedge CLK);
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    do begin @(negedge CLK); r = HREADYOUT; @(posedge CLK); end while (r !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do begin @(negedge CLK); r = HREADYOUT; q = HRDATA; @(posedge CLK); end while (r !== 1'b1);
  endtask
  task automatic waitfor(input int sel, input string nm);
    for (int i = 0; i < 300 && mon[sel] !== 1'b1; i++) @(negedge CLK);
    chk(nm, 32'h1, {31'h0, mon[sel]});
  endtask
  task automatic pulse_ev();
    repeat (4) @(posedge CLK);
    ev <= 1'b1;
    repeat (8) @(posedge CLK);
    ev <= 1'b0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {RESET, HWRITE, ev, HTRANS, HADDR, HWDATA} = {1'b1, 2'b0, 2'h0, 64'h0};
    {bad_count, samples_checked, cyc, evt_n} = {4{32'sd0}};
    repeat (8) @(posedge CLK);
    chk("safe outputs", 32'h1, {31'h0, HREADYOUT && !OUT_ENABLE && !MOVE_START});
    RESET <= 1'b0;
    repeat (20) @(posedge CLK);
    bus(0, `ASV_OFF_STAT, 32'h0); chk("error mode", 32'hB, {28'h0, q[9:6]});
    bus(0, `ASV_OFF_COEF, 32'h0); chk("coef reset", 32'h3E8, q);
    bus(0, 8'h40, 32'h0); chk("unmapped", 32'h0, q);
    bus(1, `ASV_OFF_CFG, 32'h1);
    repeat (5) @(posedge CLK);
    bus(0, `ASV_OFF_STAT, 32'h0); chk("off mode", 32'h9, {27'h0, q[9:5]});
    bus(1, `ASV_OFF_CTRL, 32'hF);
    bus(0, `ASV_OFF_STAT, 32'h0); chk("run mode", 32'h3, {29'h0, q[9:7]});
    bus(1, `ASV_OFF_CMD, 32'h0064_0009);
    waitfor(0, "first start"); chk("speed", 32'h64, MOVE_SPEED);
    chk("code", 32'h9, {24'h0, MOVE_CODE});
    bus(1, `ASV_OFF_CMD, 32'h012C_0009);
    waitfor(1, "paused"); chk("held back", 32'h0, {31'h0, MOVE_START});
    bus(1, `ASV_OFF_CTRL, 32'hE);
    waitfor(0, "resume start"); chk("speed", 32'h12C, MOVE_SPEED);
    chk("pause flag", 32'h0, {31'h0, PAUSED});
    bus(1, `ASV_OFF_CMD, 32'h07D0_000A);
    waitfor(0, "hold move start");
    bus(1, `ASV_OFF_COEF, 32'h0);
    waitfor(2, "feed hold");
    @(negedge CLK); chk("hold decel", 32'h1, {31'h0, DECEL_REQ});
    repeat (10) @(posedge CLK);
    bus(1, `ASV_OFF_COEF, 32'h1F4);
    waitfor(0, "hold resume"); chk("scaled speed", 32'h3E8, MOVE_SPEED);
    bus(0, `ASV_OFF_SPD, 32'h0); chk("speed word", 32'h3E8, q);
    bus(1, `ASV_OFF_CMD, 32'h0000_0005);
    waitfor(0, "await start"); pulse_ev();
    repeat (20) @(posedge CLK);
    chk("no trigger", 32'h0, evt_n);
    for (int k = 0; k < 2; k++) begin
      bus(1, `ASV_OFF_CMD, 32'h0000_1005);
      waitfor(0, "await start"); pulse_ev();
      chk("event trigger", k + 1, evt_n);
      bus(0, `ASV_OFF_EVT, 32'h0); chk("event word", k ? 32'h32 : 32'h22, q);
    end
    bus(1, `ASV_OFF_EVT, 32'h1);
    bus(0, `ASV_OFF_EVT, 32'h0); chk("event ack", 32'h0, q & 32'h30);
    bus(1, `ASV_OFF_CMD, 32'h0000_1005); waitfor(0, "timeout start");
    repeat (60) @(posedge CLK);
    chk("timeout trigger", 32'h3, evt_n);
    bus(0, `ASV_OFF_EVT, 32'h0); chk("timeout word", 32'h24, q);
    bus(1, `ASV_OFF_CMD, 32'h0000_1007); waitfor(0, "capture start");
    pos = POSITION;
    pulse_ev();
    repeat (4) @(posedge CLK);
    chk("capture trigger", 32'h4, evt_n);
    bus(0, `ASV_OFF_EVT, 32'h0); chk("capture word", 32'h31, q);
    bus(0, `ASV_OFF_CAPT, 32'h0); chk("captured position", pos, q);
    bus(1, `ASV_OFF_CMD, 32'h0064_0009);
    waitfor(0, "held start"); chk("scaled start", 32'h32, MOVE_SPEED);
    bus(1, `ASV_OFF_COEF, 32'h0); waitfor(2, "second hold");
    bus(1, `ASV_OFF_CTRL, 32'h1E);
    @(negedge CLK); chk("hold cancelled", 32'h0, {31'h0, FEED_HOLD});
    bus(1, `ASV_OFF_CTRL, 32'h8);
    repeat (30) @(posedge CLK);
    bus(0, `ASV_OFF_STAT, 32'h0); chk("stop to off", 32'h2, {29'h0, q[9:7]});
    chk("outputs safe", 32'h0, {31'h0, OUT_ENABLE});
    report_and_stop();
  end
endmodule
